// File: rtl/tmz_cycle_gen.sv
// Instruction cycle strobe: one mclk pulse every DIV oscillator periods.
// Assumes mclk is the oscillator clock of the timer.
`timescale 1ns/1ps
`include "tmz_regs.svh"
module tmz_cycle_gen #(
   parameter int DIV = `TMZ_CYCLE_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   output logic cycle_tick
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] phase_q;
   // ****************************************************************
   // Phase counter
   // ****************************************************************
   // Free running phase, wraps at the last oscillator period
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_q <= '0;
      end else if (phase_q == CW'(DIV - 1)) begin
         phase_q <= '0;
      end else begin
         phase_q <= phase_q + CW'(1);
      end
   end
   // Strobe on the last phase so the first one comes DIV clocks in
   assign cycle_tick = (phase_q == CW'(DIV - 1));
endmodule

// File: rtl/tmz_edge_sync.sv
// Three-stage synchroniser with edge detect for the count input pin.
// Assumes the pin is asynchronous to mclk and slower than mclk / 4.
`timescale 1ns/1ps
module tmz_edge_sync (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic rise,
   output logic fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   // ****************************************************************
   // Synchroniser chain
   // ****************************************************************
   // First stage feeds the second stage only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Accepted level moves only once stages two and three agree
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         level_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end
   // One-cycle edge pulses against the accepted level
   assign rise = (s2_q == s3_q) && s3_q && !level_q;
   assign fall = (s2_q == s3_q) && !s3_q && level_q;
endmodule

// File: rtl/tmz_pkg.sv
// Types shared by the timer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tmz_pkg;
   // ****************************************************************
   // Bus handshake states and response codes
   // ****************************************************************
   typedef enum logic [0:0] {
      TMZ_CH_IDLE = 1'b0,
      TMZ_CH_RESP = 1'b1
   } tmz_chan_t;
   typedef enum logic [1:0] {
      TMZ_RESP_OKAY = 2'b00,
      TMZ_RESP_SLVERR = 2'b10
   } tmz_resp_t;
endpackage

// File: rtl/tmz_regs.svh
// Register offsets, field positions, reset values and counts of the timer.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef TMZ_REGS_SVH
`define TMZ_REGS_SVH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define TMZ_ADDR_COUNT 8'h00
`define TMZ_ADDR_OPTION 8'h04
// ****************************************************************
// Option register fields and reset values
// ****************************************************************
`define TMZ_OPT_PS_LSB 0
`define TMZ_OPT_PS_MSB 2
`define TMZ_OPT_PSA_BIT 3
`define TMZ_OPT_SE_BIT 4
`define TMZ_OPT_CS_BIT 5
`define TMZ_OPT_WIDTH 6
`define TMZ_OPT_RESET 6'h3F
`define TMZ_COUNT_RESET 8'h00
// ****************************************************************
// Timing counts
// ****************************************************************
`define TMZ_CYCLE_DIV 4
`define TMZ_WRITE_HOLD 2'h2
`endif

// File: rtl/tmz_timer.sv
// Eight-bit timer/counter with shared prescaler, AXI4-Lite register access.
// Assumes mclk is the oscillator, rst_n synchronous, one master on the bus.
// Functional notes
// RL1: The counter is eight bits, read and written by software at any time.
// RL2: With clock source select low the counter counts instruction cycles.
// RL3: In timer mode without prescaler it steps once per instruction cycle.
// RL4: A software write stops incrementing for the next two cycles.
// RL5: With clock source select high it counts edges on the count input.
// RL6: Edge select low counts rising edges, high counts falling edges.
// RL7: The one prescaler serves the counter or the watchdog, never both.
// RL8: Assign bit low gives the prescaler to the counter, high to watchdog.
// RL9: Software can neither read nor write the prescaler count.
// RL10: Given to the counter, the prescaler divides by 2 up to 256.
// RL11: One instruction cycle lasts four oscillator periods.
// RL12: The counter wraps from all ones to zero and keeps counting.
// RL13: Pin edges are synchronised to mclk before they count.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tmz_regs.svh"
module tmz_timer #(
   parameter int AW = 8,
   parameter int PRE_W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic external_count_input,
   input wire logic watchdog_tick_in,
   output logic watchdog_tick_out
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   tmz_pkg::tmz_chan_t wr_state_q;
   tmz_pkg::tmz_chan_t rd_state_q;
   logic aw_have_q;
   logic w_have_q;
   logic [AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [7:0] timer_count_q;
   logic [7:0] timer_count_d;
   logic [`TMZ_OPT_WIDTH-1:0] option_q;
   logic [1:0] hold_q;
   logic [PRE_W-1:0] pre_q;
   logic wdt_out_q;
   logic cycle_tick;
   logic pin_rise;
   logic pin_fall;
   logic wr_fire;
   logic wr_count;
   logic wr_option;
   logic clock_source_select;
   logic source_edge_select;
   logic prescaler_assign;
   logic [2:0] ps_sel;
   logic pin_event;
   logic src_event;
   logic pre_event;
   logic pre_hit;
   logic count_tick;
   logic count_inc;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Low bits of the prescaler that must all be ones for a hit
   function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
      logic [PRE_W-1:0] m;
      m = '0;
      for (int i = 0; i < PRE_W; i++) begin
         m[i] = (i <= int'(sel));
      end
      return m;
   endfunction

   // Word match against a register offset
   function automatic logic addr_is(input logic [AW-1:0] a,
                                    input logic [7:0] off);
      return (a[AW-1:2] == AW'(off) >> 2);
   endfunction

   // ****************************************************************
   // Clock sources
   // ****************************************************************
   // Instruction cycle strobe from the oscillator
   tmz_cycle_gen u_cycle ( // RL11
      .mclk(mclk),
      .rst_n(rst_n),
      .cycle_tick(cycle_tick)
   );

   // Pin conditioning before any count logic sees it
   tmz_edge_sync u_sync ( // RL13
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_in(external_count_input),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ****************************************************************
   // Option fields
   // ****************************************************************
   assign clock_source_select = option_q[`TMZ_OPT_CS_BIT];
   assign source_edge_select = option_q[`TMZ_OPT_SE_BIT];
   assign prescaler_assign = option_q[`TMZ_OPT_PSA_BIT];
   assign ps_sel = option_q[`TMZ_OPT_PS_MSB:`TMZ_OPT_PS_LSB];

   // Edge choice for counter mode
   assign pin_event = source_edge_select ? pin_fall : pin_rise; // RL6
   // Count source: instruction cycle or pin edge
   assign src_event = clock_source_select ? pin_event : cycle_tick; // RL2 RL5

   // ****************************************************************
   // Shared prescaler
   // ****************************************************************
   // Prescaler input follows its owner only
   assign pre_event = prescaler_assign ? watchdog_tick_in : src_event; // RL7
   assign pre_hit = pre_event && ((pre_q & div_mask(ps_sel)) ==
                                  div_mask(ps_sel)); // RL10

   // Internal count, no bus path reaches it
   always_ff @(posedge mclk) begin // RL9
      if (!rst_n) begin
         pre_q <= '0;
      end else if (pre_event) begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   // Counter sees divided events only when it owns the prescaler
   assign count_tick = prescaler_assign ? src_event : pre_hit; // RL8 RL3

   // Watchdog sees divided ticks only when it owns the prescaler
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wdt_out_q <= 1'b0;
      end else begin
         wdt_out_q <= prescaler_assign ? pre_hit : watchdog_tick_in; // RL8
      end
   end
   assign watchdog_tick_out = wdt_out_q;

   // ****************************************************************
   // Write channel
   // ****************************************************************
   // Address and data may arrive in either order
   assign s_axi_awready = !aw_have_q && (wr_state_q == tmz_pkg::TMZ_CH_IDLE);
   assign s_axi_wready = !w_have_q && (wr_state_q == tmz_pkg::TMZ_CH_IDLE);
   assign wr_fire = aw_have_q && w_have_q;
   assign wr_count = wr_fire && addr_is(awaddr_q, `TMZ_ADDR_COUNT)
                     && wstrb_q[0];
   assign wr_option = wr_fire && addr_is(awaddr_q, `TMZ_ADDR_OPTION)
                      && wstrb_q[0];

   // Capture address and data, then answer with a response
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_state_q <= tmz_pkg::TMZ_CH_IDLE;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= 2'h0;
      end else begin
         case (wr_state_q)
            tmz_pkg::TMZ_CH_IDLE: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_have_q <= 1'b1;
                  awaddr_q <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_have_q <= 1'b1;
                  wdata_q <= s_axi_wdata;
                  wstrb_q <= s_axi_wstrb;
               end
               if (wr_fire) begin
                  aw_have_q <= 1'b0;
                  w_have_q <= 1'b0;
                  wr_state_q <= tmz_pkg::TMZ_CH_RESP;
                  if (addr_is(awaddr_q, `TMZ_ADDR_COUNT) ||
                      addr_is(awaddr_q, `TMZ_ADDR_OPTION)) begin
                     bresp_q <= tmz_pkg::TMZ_RESP_OKAY;
                  end else begin
                     bresp_q <= tmz_pkg::TMZ_RESP_SLVERR;
                  end
               end
            end
            tmz_pkg::TMZ_CH_RESP: begin
               if (s_axi_bready) begin
                  wr_state_q <= tmz_pkg::TMZ_CH_IDLE;
               end
            end
            default: begin
               wr_state_q <= tmz_pkg::TMZ_CH_IDLE;
            end
         endcase
      end
   end
   assign s_axi_bvalid = (wr_state_q == tmz_pkg::TMZ_CH_RESP);
   assign s_axi_bresp = bresp_q;

   // ****************************************************************
   // Read channel
   // ****************************************************************
   // Read data is sampled at the address edge; prescaler never shown
   assign s_axi_arready = (rd_state_q == tmz_pkg::TMZ_CH_IDLE);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd_state_q <= tmz_pkg::TMZ_CH_IDLE;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end else begin
         case (rd_state_q)
            tmz_pkg::TMZ_CH_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state_q <= tmz_pkg::TMZ_CH_RESP;
                  rresp_q <= tmz_pkg::TMZ_RESP_OKAY;
                  if (addr_is(s_axi_araddr, `TMZ_ADDR_COUNT)) begin
                     rdata_q <= {24'h00_0000, timer_count_q}; // RL1
                  end else if (addr_is(s_axi_araddr, `TMZ_ADDR_OPTION)) begin
                     rdata_q <= {26'h0, option_q};
                  end else begin
                     rdata_q <= 32'h0000_0000;
                     rresp_q <= tmz_pkg::TMZ_RESP_SLVERR;
                  end
               end
            end
            tmz_pkg::TMZ_CH_RESP: begin
               if (s_axi_rready) begin
                  rd_state_q <= tmz_pkg::TMZ_CH_IDLE;
               end
            end
            default: begin
               rd_state_q <= tmz_pkg::TMZ_CH_IDLE;
            end
         endcase
      end
   end
   assign s_axi_rvalid = (rd_state_q == tmz_pkg::TMZ_CH_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ****************************************************************
   // Option register
   // ****************************************************************
   // Low byte lane only; upper bits of the byte are ignored
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         option_q <= `TMZ_OPT_RESET;
      end else if (wr_option) begin
         option_q <= wdata_q[`TMZ_OPT_WIDTH-1:0];
      end
   end

   // ****************************************************************
   // Counter and write hold-off
   // ****************************************************************
   // Hold-off counts instruction cycles, whatever the count source
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hold_q <= 2'h0;
      end else if (wr_count) begin
         hold_q <= `TMZ_WRITE_HOLD; // RL4
      end else if (cycle_tick && hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end

   assign count_inc = count_tick && (hold_q == 2'h0); // RL4

   // Software write wins over an increment in the same cycle
   always_comb begin
      timer_count_d = timer_count_q;
      if (wr_count) begin
         timer_count_d = wdata_q[7:0]; // RL1
      end else if (count_inc) begin
         timer_count_d = timer_count_q + 8'h01; // RL12
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         timer_count_q <= `TMZ_COUNT_RESET;
      end else begin
         timer_count_q <= timer_count_d;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_cycle_gap;
      !cycle_tick [*3] ##1 cycle_tick;
   endsequence

   sequence s_write_count;
      wr_count ##1 (hold_q == 2'h2);
   endsequence

   AST_WRITE_LOADS: assert property ( // RL1
      wr_count |=> timer_count_q == $past(wdata_q[7:0]))
      else $error("count did not load written value");

   AST_READ_COUNT: assert property ( // RL1
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == AW'(0))
      |=> s_axi_rdata == {24'h00_0000, $past(timer_count_q)})
      else $error("read did not return the count");

   AST_TIMER_STEP: assert property ( // RL3
      (!clock_source_select && prescaler_assign && cycle_tick &&
       hold_q == 2'h0 && !wr_count)
      |=> timer_count_q == $past(timer_count_q) + 8'h01)
      else $error("timer mode missed an instruction cycle");

   AST_HOLD_TWO: assert property ( // RL4
      s_write_count |-> (!count_inc) [*5])
      else $error("increment during write hold-off");

   AST_CYCLE_FOUR: assert property ( // RL11
      cycle_tick |=> s_cycle_gap)
      else $error("instruction cycle not four clocks");

   AST_PIN_ONLY: assert property ( // RL5
      (clock_source_select && !pin_rise && !pin_fall && !wr_count)
      |=> timer_count_q == $past(timer_count_q))
      else $error("counter mode moved without a pin edge");

   AST_EDGE_SEL: assert property ( // RL6
      (clock_source_select && prescaler_assign && !source_edge_select &&
       pin_fall && !wr_count) |=> $stable(timer_count_q))
      else $error("falling edge counted in rising mode");

   AST_WRAP: assert property ( // RL12
      (timer_count_q == 8'hFF && count_inc && !wr_count)
      |=> timer_count_q == 8'h00)
      else $error("counter did not wrap to zero");

   AST_WDT_BYPASS: assert property ( // RL7
      !prescaler_assign |=> watchdog_tick_out == $past(watchdog_tick_in))
      else $error("watchdog divided while prescaler on counter");

   AST_DIV_TWO: assert property ( // RL10
      (!prescaler_assign && ps_sel == 3'h0 && src_event && pre_q[0] &&
       hold_q == 2'h0 && !wr_count && !wr_option)
      |=> timer_count_q == $past(timer_count_q) + 8'h01)
      else $error("prescaler 1:2 did not step the counter");
endmodule

// File: test/timer0_with_prescaler_test.sv
// Self-checking bench of the timer: register bus, pin and watchdog paths.
// Assumes the design files and the pin source model are compiled first.
`timescale 1ns/1ps
`include "tmz_regs.svh"
module timer0_with_prescaler_test;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [1:0] OKR = tmz_pkg::TMZ_RESP_OKAY;
   localparam logic [1:0] ERR = tmz_pkg::TMZ_RESP_SLVERR;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic watchdog_tick_in = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, watchdog_tick_out, external_count_input;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [31:0] rnd_q = 32'h0001752D;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int wd_outs = 0;

   tmz_timer u_tmz_timer (
      .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .external_count_input,
      .watchdog_tick_in, .watchdog_tick_out
   );
   tmz_pin_src u_tmz_pin_src (
      .count_pin(external_count_input)
   );

   // 125 MHz clock, edge stamps and watchdog pulse tally
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (watchdog_tick_out === 1'b1) begin
         wd_outs <= wd_outs + 1;
      end
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Edges of one polarity in m toggles starting from level lvl
   function automatic logic [31:0] edges(input int lvl, input int m,
                                         input int se);
      int rises;
      rises = (lvl == 0) ? (m + 1) / 2 : m / 2;
      return (se == 0) ? 32'(rises) : 32'(m - rises);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t ns: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   // Write; sb is the stamp of the edge that sees bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er,
                     output int sb);
      logic aw_ok = 1'b0;
      logic w_ok = 1'b0;
      logic b_ok = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64 && !b_ok; n++) begin
         @(posedge mclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid === 1'b1) begin
            b_ok = 1'b1;
            sb = cyc;
            s_axi_bready <= 1'b0;
            check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
         end
      end
      check({31'h0, b_ok}, 32'h1, "write answered");
   endtask

   // Read; st above zero means the address is taken at stamp st
   task automatic axi_rd(input logic [7:0] a, input int st,
                         output logic [31:0] d, output logic [1:0] r,
                         output int tk);
      logic ar_ok = 1'b0;
      logic r_ok = 1'b0;
      do @(posedge mclk); while (st > 0 && cyc != st - 1);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64 && !r_ok; n++) begin
         @(posedge mclk);
         if (!ar_ok && s_axi_arready === 1'b1) begin
            ar_ok = 1'b1;
            tk = cyc;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid === 1'b1) begin
            r_ok = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      check({31'h0, r_ok}, 32'h1, "read answered");
   endtask

   task automatic rd_chk(input logic [7:0] a, input int st,
                         input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      int tk;
      axi_rd(a, st, d, r, tk);
      check(d, ed, "read data");
      check({30'h0, r}, {30'h0, er}, "read response");
   endtask

   task automatic conclude();
      $display("compared %0d, mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   // Cut a hang short; the whole run needs about 4500 clocks
   initial begin
      repeat (30000) @(posedge mclk);
      $display("unexpected at %0t ns: run did not finish", $time);
      failures++;
      conclude();
   end

   initial begin
      logic [31:0] d, c0;
      logic [1:0] r;
      int sb, t1, m, lvl, w0, per;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values, unmapped places, ignored bits and strobes
      rd_chk(`TMZ_ADDR_COUNT, 0, {24'h0, `TMZ_COUNT_RESET}, OKR);
      rd_chk(`TMZ_ADDR_OPTION, 0, {26'h0, `TMZ_OPT_RESET}, OKR);
      rd_chk(8'h08, 0, 32'h0, ERR);
      rnd_q = lfsr(rnd_q);
      wr(8'h0C, rnd_q, 4'hF, ERR, sb);
      wr(`TMZ_ADDR_OPTION, {rnd_q[31:6], 6'h08}, 4'h1, OKR, sb);
      wr(`TMZ_ADDR_OPTION, 32'h3F, 4'h0, OKR, sb);
      rd_chk(`TMZ_ADDR_OPTION, 0, 32'h08, OKR);
      $display("test registers done");
      // Pin edges of each polarity, bursts of 5 to 12 toggles from the running level
      lvl = 0;
      for (int se = 0; se < 2; se++) begin
         wr(`TMZ_ADDR_OPTION, {26'h0, 1'b1, se[0], 4'h8}, 4'h1, OKR, sb);
         axi_rd(`TMZ_ADDR_COUNT, 0, c0, r, t1);
         rnd_q = lfsr(rnd_q);
         m = 5 + int'(rnd_q[2:0]);
         u_tmz_pin_src.toggles(m);
         repeat (12) @(posedge mclk);
         axi_rd(`TMZ_ADDR_COUNT, 0, d, r, t1);
         check((d - c0) & 32'hFF, edges(lvl, m, se), "pin edges");
         lvl = (lvl + m) % 2;
      end
      $display("test counter mode done");
      // Write hold-off and wrap: 12 edges after the write edge hold
      // exactly three cycle strobes, two of them swallowed
      wr(`TMZ_ADDR_OPTION, 32'h08, 4'h1, OKR, sb);
      for (int i = 0; i < 4; i++) begin
         rnd_q = lfsr(rnd_q);
         d = (i == 0) ? 32'hFF : (i == 1) ? 32'hFE : {24'h0, rnd_q[7:0]};
         wr(`TMZ_ADDR_COUNT, {rnd_q[31:8], d[7:0]}, 4'h1, OKR, sb);
         rd_chk(`TMZ_ADDR_COUNT, sb + 6, d, OKR);
         rd_chk(`TMZ_ADDR_COUNT, sb + 12, (d + 1) & 32'hFF, OKR);
      end
      $display("test hold-off done");
      // Rates: two full prescaled periods give exactly two steps;
      // select 8 stands for the prescaler given to the watchdog
      for (int sel = 0; sel < 9; sel++) begin
         d = (sel == 8) ? 32'h08 : 32'(sel);
         wr(`TMZ_ADDR_OPTION, d, 4'h1, OKR, sb);
         per = (sel == 8) ? 4 : 4 << (sel + 1);
         axi_rd(`TMZ_ADDR_COUNT, 0, c0, r, t1);
         axi_rd(`TMZ_ADDR_COUNT, t1 + 2 * per, d, r, t1);
         check((d - c0) & 32'hFF, 32'h2, "steps per period");
      end
      $display("test prescaler done");
      // Watchdog path: straight through, then divided by 2 and by 4
      for (int j = 0; j < 3; j++) begin
         d = (j == 0) ? 32'h00 : 32'h08 + 32'(j - 1);
         wr(`TMZ_ADDR_OPTION, d, 4'h1, OKR, sb);
         w0 = wd_outs;
         repeat (8) begin
            @(posedge mclk);
            watchdog_tick_in <= 1'b1;
            @(posedge mclk);
            watchdog_tick_in <= 1'b0;
            repeat (2) @(posedge mclk);
         end
         repeat (4) @(posedge mclk);
         check(32'(wd_outs - w0), 32'(8 >> j), "watchdog ticks");
      end
      $display("test watchdog done");
      conclude();
   end
endmodule

// File: test/tmz_pin_src.sv
// Model of the external event source that drives the count input pin.
// Assumes the bench calls toggles() and waits for it to return.
`timescale 1ns/1ps
module tmz_pin_src (
   output logic count_pin
);
   // Pin idles low until the first burst
   initial count_pin = 1'b0;

   // Each level holds 32 to 48 ns, above three mclk periods; the bench
   // calls in on a rising edge, so the 2 ns shift keeps edges off mclk
   task automatic toggles(input int m);
      #2;
      for (int i = 0; i < m; i++) begin
         #(32 + 8 * (i % 3));
         count_pin = ~count_pin;
      end
      #40;
   endtask
endmodule
